// ---- core/uaf_uart.sv ----
// serial port with multiprocessor automatic address recognition, wishbone slave
//
// Our own choice: register access over Wishbone.
`include "uaf_consts.svh"
module uaf_uart #(
    parameter logic [15:0] VAR_DIV = `UAF_VAR_DIV
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        rxd,
    output logic             txd,
    output logic             sclk_out
);
    // register state
    logic [7:0]  sctl_r;
    logic [7:0]  slave_address_r;
    logic [7:0]  smask_r;
    logic [7:0]  aux_r;
    logic        fe_r;
    logic        sm0_r;
    logic [7:0]  rx_data_r;
    logic        ack_r;
    logic        err_r;
    logic [31:0] rdat_r;

    // bus decode
    logic [7:0]  idx;
    logic        req;
    logic        wr;
    logic        lane0;
    logic        hit_sctl;
    logic        hit_slave_address;
    logic        hit_smask;
    logic        hit_data;
    logic        hit_aux;
    logic        hit_bset;
    logic        hit_bclr;
    logic        mapped;
    logic [7:0]  rd_byte;
    logic [7:0]  sctl_view;

    assign idx       = wb_adr_i[9:2];
    assign req       = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
    assign wr        = req & wb_we_i & wb_sel_i[0];
    assign lane0     = wb_sel_i[0];
    assign hit_sctl  = idx == `UAF_IDX_SCTL;
    assign hit_slave_address = idx == `UAF_IDX_SLAVE_ADDRESS;
    assign hit_smask = idx == `UAF_IDX_SMASK;
    assign hit_data  = idx == `UAF_IDX_DATA;
    assign hit_aux   = idx == `UAF_IDX_AUX;
    assign hit_bset  = idx == `UAF_IDX_BITSET;
    assign hit_bclr  = idx == `UAF_IDX_BITCLR;
    assign mapped    = hit_sctl | hit_slave_address | hit_smask | hit_data | hit_aux | hit_bset
                     | hit_bclr;

    // bit 7 shows error flag or mode bit depending on select
    assign sctl_view = {aux_r[`UAF_B_ERRSEL] ? fe_r : sm0_r, sctl_r[6:0]};

    assign rd_byte = hit_sctl  ? sctl_view :
                     hit_slave_address ? slave_address_r :
                     hit_smask ? smask_r :
                     hit_data  ? rx_data_r :
                     hit_aux   ? aux_r : 8'h00;

    // mode decode
    logic [1:0]  mode_bits;
    logic        is_shift;
    logic        is_nine;
    logic        mpe_on;
    logic        errsel;
    logic        dbl;
    assign mode_bits = {sm0_r, sctl_r[`UAF_B_MODE_LO]};
    assign is_shift  = mode_bits == 2'b00;
    assign is_nine   = mode_bits[1];
    assign mpe_on    = sctl_r[`UAF_B_MPE] & ~is_shift;
    assign errsel    = aux_r[`UAF_B_ERRSEL];
    assign dbl       = aux_r[`UAF_B_DBL];

    function automatic logic [15:0] bit_div(input logic [1:0] m, input logic x2);
        if (m == 2'b00) begin
            bit_div = x2 ? `UAF_SHIFT_DIV_X2 : `UAF_SHIFT_DIV;
        end else if (m == 2'b10) begin
            bit_div = x2 ? `UAF_M2_DIV_X2 : `UAF_M2_DIV;
        end else begin
            bit_div = VAR_DIV;
        end
    endfunction : bit_div

    logic [15:0] div;
    assign div = bit_div(mode_bits, dbl);

    // rx pin synchroniser
    logic rx_s1_r;
    logic rx_s2_r;
    always_ff @(posedge clk) begin
        rx_s1_r <= reset ? 1'b1 : rxd;
        rx_s2_r <= reset ? 1'b1 : rx_s1_r;
    end

    // receiver
    uaf_pkg::uaf_rx_state_t rx_st_r;
    logic [15:0] rx_cnt_r;
    logic [3:0]  rx_bit_r;
    logic [8:0]  rx_sh_r;
    logic        rx_mpe_r;
    logic        rx_tick;
    logic [3:0]  rx_nbits;
    logic        addr_hit;
    logic        rx_ninth;
    logic        rx_accept;
    logic        rx_done;
    logic        rx_data_end;
    logic        rx_fe_ev;
    logic        rx_ri_set;
    logic        rx_rb8_load;

    assign rx_tick  = rx_cnt_r == 16'h0000;
    assign rx_nbits = is_nine ? 4'd9 : 4'd8;

    uaf_addr_match u_match (
        .rx_addr    (rx_sh_r[7:0]),
        .slave_addr (slave_address_r),
        .slave_mask (smask_r),
        .hit        (addr_hit)
    );

    // uart mode 1 ninth bit is the stop bit itself
    assign rx_ninth    = is_nine ? rx_sh_r[8] : rx_s2_r;
    // with filtering, only ninth-bit-one frames that match are taken
    assign rx_accept   = ~mpe_on | (rx_ninth & addr_hit &
                         (is_nine | rx_s2_r));
    assign rx_data_end = rx_st_r == uaf_pkg::UAF_RX_BITS & rx_tick
                       & rx_bit_r == rx_nbits - 4'd1;
    assign rx_done     = rx_st_r == uaf_pkg::UAF_RX_STOP & rx_tick;
    assign rx_fe_ev    = rx_done & ~rx_s2_r & errsel;
    // receive flag is set at the stop bit sample whether or not error detection is selected
    assign rx_ri_set   = rx_accept & ~sctl_r[`UAF_B_RI] &
                         (errsel ? rx_done : rx_done);
    assign rx_rb8_load = rx_done & rx_accept;

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_st_r  <= uaf_pkg::UAF_RX_IDLE;
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 4'h0;
            rx_sh_r  <= 9'h000;
        end else begin
            rx_cnt_r <= rx_tick ? div - 16'h0001 : rx_cnt_r - 16'h0001;
            case (rx_st_r)
                uaf_pkg::UAF_RX_IDLE: begin
                    // reception only while enabled and not in shift mode
                    if (sctl_r[`UAF_B_REN] & ~is_shift & ~rx_s2_r) begin
                        rx_st_r  <= uaf_pkg::UAF_RX_START;
                        rx_cnt_r <= {1'b0, div[15:1]};
                    end
                end
                uaf_pkg::UAF_RX_START: begin
                    if (rx_tick) begin
                        rx_st_r  <= rx_s2_r ? uaf_pkg::UAF_RX_IDLE : uaf_pkg::UAF_RX_BITS;
                        rx_bit_r <= 4'h0;
                    end
                end
                uaf_pkg::UAF_RX_BITS: begin
                    if (rx_tick) begin
                        rx_sh_r  <= is_nine ? {rx_s2_r, rx_sh_r[8:1]}
                                            : {1'b0, rx_s2_r, rx_sh_r[7:1]};
                        rx_bit_r <= rx_bit_r + 4'd1;
                        if (rx_data_end) begin
                            rx_st_r <= uaf_pkg::UAF_RX_STOP;
                        end
                    end
                end
                default: begin
                    if (rx_tick) begin
                        rx_st_r <= uaf_pkg::UAF_RX_IDLE;
                    end
                end
            endcase
        end
    end

    // transmitter, started by a data write
    logic        tx_busy_r;
    logic [15:0] tx_cnt_r;
    logic [3:0]  tx_bit_r;
    logic [10:0] tx_sh_r;
    logic        tx_go;
    logic        tx_tick;
    logic [3:0]  tx_last;
    logic        tx_stop_start;
    assign tx_go   = wr & hit_data & ~tx_busy_r & ~is_shift;
    assign tx_tick = tx_cnt_r == 16'h0000;
    assign tx_last = is_nine ? 4'd11 : 4'd10;
    // stop bit begins when the shifted count reaches data plus start
    assign tx_stop_start = tx_busy_r & tx_tick & tx_bit_r == tx_last - 4'd2;

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_busy_r <= 1'b0;
            tx_cnt_r  <= 16'h0000;
            tx_bit_r  <= 4'h0;
            tx_sh_r   <= 11'h7ff;
        end else if (tx_go) begin
            tx_busy_r <= 1'b1;
            tx_cnt_r  <= div - 16'h0001;
            tx_bit_r  <= 4'h0;
            tx_sh_r   <= is_nine ? {1'b1, sctl_r[`UAF_B_TB8], wb_dat_i[7:0], 1'b0}
                                 : {2'b11, wb_dat_i[7:0], 1'b0};
        end else if (tx_busy_r & tx_tick) begin
            tx_cnt_r  <= div - 16'h0001;
            tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
            tx_bit_r  <= tx_bit_r + 4'd1;
            tx_busy_r <= tx_bit_r != tx_last - 4'd1;
        end else if (tx_busy_r) begin
            tx_cnt_r <= tx_cnt_r - 16'h0001;
        end
    end

    // bit set and clear masks for the bit-addressable control register
    logic [7:0] sc_wdat;
    logic [7:0] sc_set;
    logic [7:0] sc_clr;
    logic [7:0] sctl_sw;
    assign sc_wdat = wb_dat_i[7:0];
    assign sc_set  = (wr & hit_bset) ? sc_wdat : 8'h00;
    assign sc_clr  = (wr & hit_bclr) ? sc_wdat : 8'h00;
    assign sctl_sw = (wr & hit_sctl) ? sc_wdat : ((sctl_view | sc_set) & ~sc_clr);

    // control register; hardware sets win over software clears
    logic sw_ctl;
    assign sw_ctl = wr & (hit_sctl | hit_bset | hit_bclr);
    always_ff @(posedge clk) begin
        if (reset) begin
            sctl_r <= `UAF_RST_SCTL;
            fe_r   <= 1'b0;
            sm0_r  <= 1'b0;
        end else begin
            if (sw_ctl) begin
                sctl_r[7:2] <= sctl_sw[7:2];
                sctl_r[1:0] <= sctl_sw[1:0];
                if (errsel) begin
                    fe_r <= sctl_sw[7];
                end else begin
                    sm0_r <= sctl_sw[7];
                end
            end
            if (rx_rb8_load & is_nine) begin
                sctl_r[`UAF_B_RB8] <= rx_ninth;
            end else if (rx_rb8_load) begin
                sctl_r[`UAF_B_RB8] <= rx_s2_r;
            end
            if (rx_ri_set) begin
                sctl_r[`UAF_B_RI] <= 1'b1;
            end
            if (tx_stop_start) begin
                sctl_r[`UAF_B_TI] <= 1'b1;
            end
            // sticky: a good stop bit never clears it
            if (rx_fe_ev) begin
                fe_r <= 1'b1;
            end
        end
    end

    // address, mask, aux and receive data registers
    always_ff @(posedge clk) begin
        if (reset) begin
            slave_address_r   <= `UAF_RST_SLAVE_ADDRESS;
            smask_r   <= `UAF_RST_SMASK;
            aux_r     <= `UAF_RST_AUX;
            rx_data_r <= 8'h00;
        end else begin
            if (wr & hit_slave_address) begin
                slave_address_r <= sc_wdat;
            end
            if (wr & hit_smask) begin
                smask_r <= sc_wdat;
            end
            if (wr & hit_aux) begin
                aux_r <= {6'h00, sc_wdat[1:0]};
            end
            if (rx_ri_set) begin
                rx_data_r <= rx_sh_r[7:0];
            end
        end
    end

    // wishbone answer: one cycle after request, err on unmapped index
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_r  <= 1'b0;
            err_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= req & mapped;
            err_r  <= req & ~mapped;
            rdat_r <= {24'h00_0000, lane0 ? rd_byte : 8'h00};
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = rdat_r;
    // shifter fills with ones, so its low bit is idle-high between frames
    assign txd      = tx_sh_r[0];
    assign sclk_out = 1'b1; // shift-register mode datapath not built
endmodule : uaf_uart

// ---- common/uaf_consts.svh ----
// offsets, field positions, reset values and timing counts of the address filter uart
`ifndef UAF_CONSTS_SVH
`define UAF_CONSTS_SVH
// printed offsets are not multiples of four: kept as indices, byte address = 4 * index
`define UAF_IDX_SCTL      8'h98
`define UAF_IDX_SLAVE_ADDRESS     8'ha9
`define UAF_IDX_SMASK     8'hb9
`define UAF_IDX_DATA      8'h99
`define UAF_IDX_AUX       8'hc0
`define UAF_IDX_BITSET    8'hc1
`define UAF_IDX_BITCLR    8'hc2
// serial control fields
`define UAF_B_MODE_HI     7
`define UAF_B_MODE_LO     6
`define UAF_B_MPE         5
`define UAF_B_REN         4
`define UAF_B_TB8         3
`define UAF_B_RB8         2
`define UAF_B_TI          1
`define UAF_B_RI          0
// aux register fields
`define UAF_B_ERRSEL      0
`define UAF_B_DBL         1
`define UAF_RST_SCTL      8'h00
`define UAF_RST_SLAVE_ADDRESS     8'h00
`define UAF_RST_SMASK     8'h00
`define UAF_RST_AUX       8'h00
// bit period in clk cycles for variable rate modes, then shift and fixed-rate modes (no baud generator here)
`define UAF_VAR_DIV       16'd868
`define UAF_SHIFT_DIV     16'd12
`define UAF_SHIFT_DIV_X2  16'd6
`define UAF_M2_DIV        16'd64
`define UAF_M2_DIV_X2     16'd32
`endif

// ---- common/uaf_pkg.sv ----
// types shared by the address filter uart
package uaf_pkg;
    typedef enum logic [1:0] {
        UAF_MODE_SHIFT,
        UAF_MODE_UART8,
        UAF_MODE_UART9_FIX,
        UAF_MODE_UART9_VAR
    } uaf_mode_t;
    typedef enum logic [1:0] {
        UAF_RX_IDLE,
        UAF_RX_START,
        UAF_RX_BITS,
        UAF_RX_STOP
    } uaf_rx_state_t;
endpackage : uaf_pkg

// ---- core/uaf_addr_match.sv ----
// address match for given and broadcast address
module uaf_addr_match (
    input  wire logic [7:0] rx_addr,
    input  wire logic [7:0] slave_addr,
    input  wire logic [7:0] slave_mask,
    output logic            hit
);
    logic [7:0] bcast;
    logic       given_hit;
    logic       bcast_hit;
    // zero mask bits are don't-care in the given comparison; broadcast ignores only bits zero in both address and mask
    assign given_hit = ((rx_addr ^ slave_addr) & slave_mask) == 8'h00;
    assign bcast     = slave_addr | slave_mask;
    assign bcast_hit = ((rx_addr ^ bcast) & bcast) == 8'h00;
    assign hit       = given_hit | bcast_hit;
endmodule : uaf_addr_match

// ---- bench/uaf_uart_properties.sv ----
// port-level checker for the address filter uart
`include "uaf_consts.svh"
module uaf_uart_properties #(
    parameter logic [15:0] VAR_DIV = `UAF_VAR_DIV
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        rxd,
    input wire logic        txd,
    input wire logic        sclk_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // decode of the register indices that answer with ack
    wire logic [7:0] idx = wb_adr_i[9:2];
    wire logic       req = wb_cyc_i && wb_stb_i;
    wire logic       hit = idx inside {`UAF_IDX_SCTL, `UAF_IDX_SLAVE_ADDRESS, `UAF_IDX_SMASK,
        `UAF_IDX_DATA, `UAF_IDX_AUX, `UAF_IDX_BITSET, `UAF_IDX_BITCLR};

    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    bus_answer_a: assert property (
        (req && !wb_ack_o && !wb_err_o) |=> (wb_ack_o != wb_err_o))
        else $error("request not answered by exactly one of ack and err");
    err_unmapped_a: assert property (wb_err_o |-> $past(req && !hit))
        else $error("err for a mapped index");
    ack_mapped_a: assert property (wb_ack_o |-> $past(req && hit))
        else $error("ack without a mapped request");
    upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    sel_off_read_a: assert property (
        (wb_ack_o && $past(!wb_we_i && !wb_sel_i[0])) |-> wb_dat_o == 32'h0)
        else $error("read without low lane gave data");
    // reset must leave the line idle regardless of the disable
    reset_idle_a: assert property (disable iff (1'b0)
        reset |=> (txd && !wb_ack_o && !wb_err_o))
        else $error("outputs not idle after reset");
    start_bit_a: assert property ($fell(txd) |-> !txd [*4])
        else $error("start bit shorter than a bit time");
    sclk_high_a: assert property (sclk_out)
        else $error("shift clock not held high");

    cover property (wb_ack_o && $past(wb_we_i));
    cover property (wb_err_o);
    cover property ($fell(txd));
endmodule : uaf_uart_properties

// ---- bench/uaf_serial_node.sv ----
// far serial node: drives the receive line and captures sent frames
module uaf_serial_node #(
    parameter int BIT_CYC = 4
) (
    input  wire logic clk,
    input  wire logic txd,
    output logic      line
);
    initial line = 1'b1;
    // one frame lsb first; stop level is the caller's, so bad stops can be sent
    task automatic send(input logic [7:0] d, input logic h9, input logic b9,
                        input logic stp);
        logic [10:0] f;
        int          n;
        f = {stp, b9, d, 1'b0};
        n = h9 ? 11 : 10;
        if (!h9) begin
            f[9] = stp;
        end
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            line <= f[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
        @(posedge clk);
        line <= 1'b1; // released line sits at its pull-up level
        repeat (2 * BIT_CYC) @(posedge clk);
    endtask : send
    // samples data and ninth bit at mid bit
    task automatic recv(input int bc, output logic [8:0] got);
        int k;
        k = 0;
        while (txd !== 1'b0 && k < 4000) begin
            @(posedge clk);
            k++;
        end
        repeat (bc / 2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (bc) @(posedge clk);
            got[i] = txd;
        end
    endtask : recv
endmodule : uaf_serial_node

// ---- bench/uaf_uart_test.sv ----
// self-checking bench for the address filter uart
`include "uaf_consts.svh"
module uaf_uart_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset, cyc, stb, we, ack, err, rxd, txd, e;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [8:0]  got;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc_cnt = 0;

    uaf_uart #(.VAR_DIV(16'h0004)) uaf_uart_inst (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .rxd(rxd), .txd(txd), .sclk_out());
    uaf_serial_node #(.BIT_CYC(4)) uaf_serial_node_inst (.clk(clk), .txd(txd), .line(rxd));

    always #5 clk = ~clk;
    // hang guard, far above the roughly 1550 cycles the run needs
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    // classic cycle held until ack or err is sampled
    task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d,
                      input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= {24'h0, d};
        sel <= s;
        do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] i);
        wb(1'b0, i, 8'h00, 4'h1);
    endtask : rd
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        wb(1'b1, i, d, 4'h1);
    endtask : wr
    // one frame in, then receive flag judged, and data and ninth bit when a hit is expected
    task automatic rx_chk(input logic [7:0] d, input logic h9, input logic b9,
                          input logic stp, input logic hit);
        uaf_serial_node_inst.send(d, h9, b9, stp);
        rd(`UAF_IDX_SCTL);
        chk("receive_done", 32'(q[0]), 32'(hit));
        if (hit) begin
            chk("ninth", 32'(q[2]), 32'(h9 ? b9 : stp));
            rd(`UAF_IDX_DATA);
            chk("rx_data", q, {24'h0, d});
        end
        wr(`UAF_IDX_BITCLR, 8'h01);
    endtask : rx_chk

    task automatic t_reset;
        rd(`UAF_IDX_SCTL);
        chk("control_reset", q, 32'h0);
        rd(`UAF_IDX_SMASK);
        chk("mask_reset", q, 32'h0);
        rd(8'h10);
        chk("unmapped_err", 32'(e), 32'h1);
        wr(`UAF_IDX_BITSET, 8'h18);
        wr(`UAF_IDX_BITCLR, 8'h08);
        rd(`UAF_IDX_SCTL);
        chk("bit_access", q, 32'h10);
        wb(1'b0, `UAF_IDX_SCTL, 8'h00, 4'h2);
        chk("lane_off_read", q, 32'h0);
    endtask : t_reset

    task automatic t_filter;
        logic [7:0] a [7] = '{8'h54, 8'h57, 8'h5e, 8'hff, 8'hfe, 8'hfd, 8'h54};
        logic       h [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        wr(`UAF_IDX_SLAVE_ADDRESS, 8'h56);
        wr(`UAF_IDX_SMASK, 8'hfc);
        rd(`UAF_IDX_SMASK);
        chk("mask_rw", q, 32'hfc);
        wr(`UAF_IDX_SCTL, 8'hf0);
        for (int i = 0; i < 7; i++) begin
            rx_chk(a[i], 1'b1, i < 6, 1'b1, h[i]);
        end
        wr(`UAF_IDX_SMASK, 8'hff);
        rx_chk(8'h54, 1'b1, 1'b1, 1'b1, 1'b0);
        rx_chk(8'h56, 1'b1, 1'b1, 1'b1, 1'b1);
        wr(`UAF_IDX_SCTL, 8'hd0);
        rx_chk(8'h12, 1'b1, 1'b0, 1'b1, 1'b1);
    endtask : t_filter

    task automatic t_mode8;
        wr(`UAF_IDX_SCTL, 8'h70);
        rx_chk(8'h56, 1'b0, 1'b0, 1'b1, 1'b1);
        rx_chk(8'h56, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_chk(8'h33, 1'b0, 1'b0, 1'b1, 1'b0);
        wr(`UAF_IDX_SCTL, 8'h40);
        rx_chk(8'h33, 1'b0, 1'b0, 1'b1, 1'b0);
        wr(`UAF_IDX_SCTL, 8'h30);
        rx_chk(8'h56, 1'b0, 1'b0, 1'b1, 1'b0);
    endtask : t_mode8

    // error flag must survive a good frame and clear only by software
    task automatic t_frame_err;
        wr(`UAF_IDX_SCTL, 8'h50);
        wr(`UAF_IDX_AUX, 8'h01);
        uaf_serial_node_inst.send(8'h11, 1'b0, 1'b0, 1'b0);
        rd(`UAF_IDX_SCTL);
        chk("frame_err_set", 32'(q[7]), 32'h1);
        wr(`UAF_IDX_BITCLR, 8'h01);
        rx_chk(8'h22, 1'b0, 1'b0, 1'b1, 1'b1);
        rd(`UAF_IDX_SCTL);
        chk("frame_err_kept", 32'(q[7]), 32'h1);
        wr(`UAF_IDX_BITCLR, 8'h80);
        rd(`UAF_IDX_SCTL);
        // last good frame left its stop bit in the ninth-bit field
        chk("frame_err_clr", q, 32'h54);
        wr(`UAF_IDX_AUX, 8'h00);
    endtask : t_frame_err

    task automatic t_tx;
        // third pass: fixed-rate nine-bit mode at double speed, 32 clocks a bit
        for (int b = 0; b < 3; b++) begin
            if (b == 2) begin
                wr(`UAF_IDX_AUX, 8'h02);
            end
            wr(`UAF_IDX_SCTL, b == 0 ? 8'hd0 : b == 1 ? 8'hd8 : 8'h88);
            fork
                wr(`UAF_IDX_DATA, 8'ha5);
                uaf_serial_node_inst.recv(b == 2 ? 32 : 4, got);
            join
            chk("tx_frame", 32'(got), {23'h0, b != 0, 8'ha5});
            repeat (b == 2 ? 40 : 8) @(posedge clk);
            rd(`UAF_IDX_SCTL);
            chk("transmit_done", 32'(q[1]), 32'h1);
            wr(`UAF_IDX_BITCLR, 8'h02);
        end
    endtask : t_tx

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 10'h0;
        sel = 4'h0;
        wdat = 32'h0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_filter();
        t_mode8();
        t_frame_err();
        t_tx();
        stop_test();
    end
endmodule : uaf_uart_test

bind uaf_uart uaf_uart_properties #(.VAR_DIV(VAR_DIV)) uaf_uart_properties_inst (
    .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .rxd(rxd), .txd(txd), .sclk_out(sclk_out));
